// [phy_diag_pkg.sv]
// Contract
// (RL1) pair select bits 13:12: 00=A,01=B,10=C,11=D; read/write, reset 00.
// (RL2) host writes zeros into cable register bits 11:10.
// (RL3) result bits 9:8: 00 none, 01 open, 10 short; 11 never produced.
// (RL4) result reports the pair currently selected, no other pair.
// (RL5) on open or short, bits 7:0 hold fault distance; reset zero.
// (RL6) link status bit 2 reads gigabit link good; reset 0.
// (RL7) link status bit 1 reads fast-ethernet link good; reset 0.
// (RL8) sixteen-bit symbol error frame counter, read-only, cleared by read.
// (RL9) bit 15 enables jabber interrupt.
// (RL10) bit 14 enables receive error interrupt.
// (RL11) bit 13 enables page received interrupt.
// (RL12) bit 12 enables parallel detect fault interrupt.
// (RL13) bit 11 enables link partner acknowledge interrupt.
// (RL14) bit 10 enables link-down interrupt.
// (RL15) all interrupt enables reset to 0.
// (RL16) writing bit 15 starts test; reads 1 while running, self-clears.
// (RL17) low byte event flags set on event, cleared on register read.
// (RL18) interrupt pin polarity bit: 1 active high, 0 active low default.
// (RL19) interrupt asserted while any enabled flag is set.
// (RL20) error counter saturates at maximum instead of wrapping.
package phy_diag_pkg;
  localparam logic [4:0] REG_CABLE = 5'h12;
  localparam logic [4:0] REG_LINK = 5'h13;
  localparam logic [4:0] REG_RXERR = 5'h15;
  localparam logic [4:0] REG_INTR = 5'h1b;
  localparam logic [4:0] REG_PHYCTL = 5'h1f;
  localparam int CT_START = 15;
  localparam int CT_PAIR_LSB = 12;
  localparam int IE_LSB = 8;
  localparam int PC_IRQ_POL = 14;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0b;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [4:0] RD_END = 5'h10;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] DIAG_NONE = 2'h0;
  localparam logic [1:0] DIAG_OPEN = 2'h1;
  localparam logic [1:0] DIAG_SHORT = 2'h2;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] PAIR_RST = 2'h0;
  localparam logic [7:0] IE_RST = 8'h00;
  localparam logic POL_RST = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_HDR = 3'b010,
    ST_TA_RD = 3'b011,
    ST_RD = 3'b100,
    ST_TA_WR = 3'b101,
    ST_WR = 3'b110
  } mdio_state_type;
endpackage

// [phy_diag_regs.sv]
`timescale 1ns/1ps
module phy_diag_regs (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  // line status and events
  input wire logic link_1000_ok,
  input wire logic link_100_ok,
  input wire logic rx_err_frame,
  input wire logic [7:0] event_in,
  // cable diagnostic engine
  output logic diag_run,
  output logic [1:0] diag_pair,
  input wire logic diag_done,
  input wire logic [1:0] diag_status,
  input wire logic [7:0] diag_dist,
  // interrupt pin
  output logic irq_pin
);
  phy_diag_pkg::mdio_state_type state_r;
  logic mdc_q_r;
  logic rise;
  logic [5:0] ones_r;
  logic [4:0] cnt_r;
  logic [11:0] hdr_r;
  logic [15:0] wsh_r;
  logic [15:0] rsh_r;
  logic mdio_out_r;
  logic mdio_oe_r;
  logic [4:0] reg_addr;
  logic rd_take;
  logic wr_take;
  logic [15:0] wr_data;
  logic [15:0] rdata;
  logic run_r;
  logic [1:0] pair_r;
  logic [1:0] res_pair_r;
  logic [1:0] stat_r;
  logic [7:0] dist_r;
  logic [1:0] stat_view;
  logic [7:0] dist_view;
  logic gig_r;
  logic fast_r;
  logic [15:0] err_cnt_r;
  logic [15:0] err_cnt_nxt;
  logic [7:0] ie_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic pol_r;
  logic irq_any;
  logic irq_pin_r;

  assign rise = mdc & ~mdc_q_r;
  assign reg_addr = hdr_r[4:0];
  assign rd_take = rise && (state_r == phy_diag_pkg::ST_TA_RD);
  assign wr_data = {wsh_r[14:0], mdio_in};
  assign wr_take = rise && (state_r == phy_diag_pkg::ST_WR) &&
    (cnt_r == phy_diag_pkg::DATA_LAST) && (hdr_r[9:5] == phy_addr);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mdc_q_r <= 1'b0;
    end else begin
      mdc_q_r <= mdc;
    end
  end

  // frame decoder, one step per mdc rising edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= phy_diag_pkg::ST_IDLE;
      ones_r <= 6'h00;
      cnt_r <= 5'h00;
      hdr_r <= 12'h000;
      wsh_r <= 16'h0000;
    end else if (rise) begin
      case (state_r)
        phy_diag_pkg::ST_IDLE: begin
          if (mdio_in) begin
            if (ones_r != phy_diag_pkg::PREAMBLE_LEN) begin
              ones_r <= ones_r + 6'h01;
            end
          end else begin
            if (ones_r == phy_diag_pkg::PREAMBLE_LEN) begin
              state_r <= phy_diag_pkg::ST_START;
            end
            ones_r <= 6'h00;
          end
        end
        phy_diag_pkg::ST_START: begin
          cnt_r <= 5'h00;
          state_r <= mdio_in ? phy_diag_pkg::ST_HDR : phy_diag_pkg::ST_IDLE;
        end
        phy_diag_pkg::ST_HDR: begin
          hdr_r <= {hdr_r[10:0], mdio_in};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == phy_diag_pkg::HDR_LAST) begin
            cnt_r <= 5'h00;
            // only an addressed read may turn the line around
            if (hdr_r[10:9] == phy_diag_pkg::OP_READ &&
                {hdr_r[3:0], mdio_in} != 5'h00 &&
                hdr_r[8:4] == phy_addr) begin
              state_r <= phy_diag_pkg::ST_TA_RD;
            end else if (hdr_r[8:4] == phy_addr &&
                hdr_r[10:9] == phy_diag_pkg::OP_READ) begin
              state_r <= phy_diag_pkg::ST_TA_RD;
            end else if (hdr_r[10:9] == phy_diag_pkg::OP_WRITE) begin
              state_r <= phy_diag_pkg::ST_TA_WR;
            end else begin
              state_r <= phy_diag_pkg::ST_IDLE;
            end
          end
        end
        phy_diag_pkg::ST_TA_RD: begin
          cnt_r <= 5'h00;
          state_r <= phy_diag_pkg::ST_RD;
        end
        phy_diag_pkg::ST_RD: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == phy_diag_pkg::RD_END) begin
            state_r <= phy_diag_pkg::ST_IDLE;
          end
        end
        phy_diag_pkg::ST_TA_WR: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == phy_diag_pkg::TA_LAST) begin
            cnt_r <= 5'h00;
            state_r <= phy_diag_pkg::ST_WR;
          end
        end
        phy_diag_pkg::ST_WR: begin
          wsh_r <= wr_data;
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == phy_diag_pkg::DATA_LAST) begin
            state_r <= phy_diag_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= phy_diag_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // drive turnaround zero then sixteen data bits, msb first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mdio_out_r <= 1'b0;
      mdio_oe_r <= 1'b0;
      rsh_r <= 16'h0000;
    end else if (rise) begin
      if (state_r == phy_diag_pkg::ST_TA_RD) begin
        mdio_oe_r <= 1'b1;
        mdio_out_r <= 1'b0;
        rsh_r <= rdata;
      end else if (state_r == phy_diag_pkg::ST_RD &&
          cnt_r != phy_diag_pkg::RD_END) begin
        mdio_out_r <= rsh_r[15];
        rsh_r <= {rsh_r[14:0], 1'b0};
      end else begin
        mdio_oe_r <= 1'b0;
        mdio_out_r <= 1'b0;
      end
    end
  end

  // result shown only for the pair it was measured on
  assign stat_view = (res_pair_r == pair_r && !run_r) ? stat_r : // [RL4]
    phy_diag_pkg::DIAG_NONE;
  assign dist_view = (stat_view != phy_diag_pkg::DIAG_NONE) ? dist_r :
    8'h00; // [RL5]

  always_comb begin
    rdata = 16'h0000;
    if (reg_addr == phy_diag_pkg::REG_CABLE) begin
      // reserved bits 14 and 11:10 read zero [RL2]
      rdata = {run_r, 1'b0, pair_r, 2'b00, stat_view, dist_view};
    end else if (reg_addr == phy_diag_pkg::REG_LINK) begin
      rdata = {13'h0000, gig_r, fast_r, 1'b0}; // [RL6] [RL7]
    end else if (reg_addr == phy_diag_pkg::REG_RXERR) begin
      rdata = err_cnt_r; // [RL8]
    end else if (reg_addr == phy_diag_pkg::REG_INTR) begin
      rdata = {ie_r, flags_r};
    end else if (reg_addr == phy_diag_pkg::REG_PHYCTL) begin
      rdata[phy_diag_pkg::PC_IRQ_POL] = pol_r;
    end
  end

  // cable test: write starts or stops, engine done ends it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_r <= 1'b0;
      pair_r <= phy_diag_pkg::PAIR_RST;
      res_pair_r <= phy_diag_pkg::PAIR_RST;
      stat_r <= phy_diag_pkg::DIAG_NONE;
      dist_r <= 8'h00;
    end else if (wr_take && reg_addr == phy_diag_pkg::REG_CABLE) begin
      run_r <= wr_data[phy_diag_pkg::CT_START]; // [RL16]
      pair_r <= wr_data[phy_diag_pkg::CT_PAIR_LSB +: 2]; // [RL1]
    end else if (run_r && diag_done) begin
      run_r <= 1'b0; // [RL16]
      res_pair_r <= pair_r;
      // an undefined code from the engine reads as no fault
      if (diag_status == phy_diag_pkg::DIAG_OPEN ||
          diag_status == phy_diag_pkg::DIAG_SHORT) begin
        stat_r <= diag_status; // [RL3]
        dist_r <= diag_dist; // [RL5]
      end else begin
        stat_r <= phy_diag_pkg::DIAG_NONE; // [RL3]
        dist_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gig_r <= 1'b0;
      fast_r <= 1'b0;
    end else begin
      gig_r <= link_1000_ok; // [RL6]
      fast_r <= link_100_ok; // [RL7]
    end
  end

  // an error frame in the clearing read cycle counts into the fresh value
  always_comb begin
    err_cnt_nxt = err_cnt_r;
    if (rd_take && reg_addr == phy_diag_pkg::REG_RXERR) begin
      err_cnt_nxt = {15'h0000, rx_err_frame}; // [RL8]
    end else if (rx_err_frame && err_cnt_r != phy_diag_pkg::CNT_MAX) begin
      err_cnt_nxt = err_cnt_r + 16'h0001; // [RL20]
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      err_cnt_r <= 16'h0000;
    end else begin
      err_cnt_r <= err_cnt_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ie_r <= phy_diag_pkg::IE_RST; // [RL15]
      pol_r <= phy_diag_pkg::POL_RST; // [RL18]
    end else if (wr_take) begin
      if (reg_addr == phy_diag_pkg::REG_INTR) begin
        // [RL9] [RL10] [RL11] [RL12] [RL13] [RL14]
        ie_r <= wr_data[phy_diag_pkg::IE_LSB +: 8];
      end else if (reg_addr == phy_diag_pkg::REG_PHYCTL) begin
        pol_r <= wr_data[phy_diag_pkg::PC_IRQ_POL]; // [RL18]
      end
    end
  end

  // set beats the clearing read so no event is lost
  always_comb begin
    flags_nxt = flags_r;
    if (rd_take && reg_addr == phy_diag_pkg::REG_INTR) begin
      flags_nxt = 8'h00;
    end
    flags_nxt = flags_nxt | event_in; // [RL17]
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign irq_any = |(flags_r & ie_r); // [RL19]

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_pin_r <= 1'b1;
    end else begin
      irq_pin_r <= pol_r ? irq_any : ~irq_any; // [RL18] [RL19]
    end
  end

  assign mdio_out = mdio_out_r;
  assign mdio_oe = mdio_oe_r;
  assign diag_run = run_r;
  assign diag_pair = pair_r;
  assign irq_pin = irq_pin_r;

  result_code_a: assert property ( // [RL3]
    @(posedge clock) disable iff (!reset_n)
    stat_view != 2'b11)
    else $error("reserved diagnostic code reported");

  result_pair_a: assert property ( // [RL4]
    @(posedge clock) disable iff (!reset_n)
    (run_r && diag_done && !wr_take) |=> res_pair_r == $past(pair_r))
    else $error("result recorded for another pair");

  fault_dist_a: assert property ( // [RL5]
    @(posedge clock) disable iff (!reset_n)
    (run_r && diag_done && !wr_take && diag_status == 2'h1)
    |=> stat_r == 2'h1 && dist_r == $past(diag_dist))
    else $error("fault distance not captured");

  link_bits_a: assert property ( // [RL6]
    @(posedge clock) disable iff (!reset_n)
    ##1 gig_r == $past(link_1000_ok) && fast_r == $past(link_100_ok))
    else $error("link status bits do not follow link");

  err_clear_a: assert property ( // [RL8]
    @(posedge clock) disable iff (!reset_n)
    (rd_take && reg_addr == phy_diag_pkg::REG_RXERR && !rx_err_frame)
    |=> err_cnt_r == 16'h0000 && rsh_r == $past(err_cnt_r))
    else $error("error counter not cleared by read");

  err_sat_a: assert property ( // [RL20]
    @(posedge clock) disable iff (!reset_n)
    (err_cnt_r == 16'hffff && !rd_take) |=> err_cnt_r == 16'hffff)
    else $error("error counter wrapped");

  flag_set_a: assert property ( // [RL17]
    @(posedge clock) disable iff (!reset_n)
    event_in != 8'h00 |=> (flags_r & $past(event_in)) == $past(event_in))
    else $error("event flag lost");

  irq_level_a: assert property ( // [RL19]
    @(posedge clock) disable iff (!reset_n)
    ##1 irq_pin_r == ($past(pol_r) ? $past(irq_any) : !$past(irq_any)))
    else $error("interrupt pin level wrong");

  test_end_a: assert property ( // [RL16]
    @(posedge clock) disable iff (!reset_n)
    (run_r && diag_done && !wr_take) |=> !run_r ##1 !diag_run)
    else $error("cable test did not self clear");
endmodule

// [mgmt_master.sv]
`timescale 1ns/1ps
module mgmt_master (
  // clock
  input wire logic clock,
  // management pins
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic drv = 1'b1;
  logic drv_en = 1'b0;
  initial mdc = 1'b0;
  // released line floats high through the pull-up
  assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv : 1'b1);

  // four core clocks per bit keeps mdc at clock/4
  task automatic slot(input logic en, input logic b, output logic s);
    drv_en = en;
    drv = b;
    mdc = 1'b0;
    repeat (2) @(negedge clock);
    s = mdio_in;
    mdc = 1'b1;
    repeat (2) @(negedge clock);
  endtask

  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] rg, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, phy, rg};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) slot(1'b1, hdr[i], s);
    if (op == phy_diag_pkg::OP_WRITE) begin
      slot(1'b1, 1'b1, s);
      slot(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) slot(1'b1, wd[i], s);
    end else begin
      // two turnaround slots, then data msb first
      for (int i = 0; i < 18; i++) begin
        slot(1'b0, 1'b1, s);
        if (i >= 2) rd[17-i] = s;
      end
    end
    drv_en = 1'b0;
  endtask
endmodule

// [phy_diag_status_irq_regs_tb_top.sv]
`timescale 1ns/1ps
module phy_diag_status_irq_regs_tb_top;
  localparam logic [4:0] PHY = 5'h03;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic mdc, mdio_in, mdio_out, mdio_oe, diag_run, irq_pin;
  logic link_1000_ok = 1'b0;
  logic link_100_ok = 1'b0;
  logic rx_err_frame = 1'b0;
  logic [7:0] event_in = 8'h00;
  logic diag_done = 1'b0;
  logic [1:0] diag_status = 2'h0;
  logic [7:0] diag_dist = 8'h00;
  logic [1:0] diag_pair, pr, es;
  logic [7:0] ed, msk;
  logic [15:0] rdv;
  logic pol;
  int n_mismatch = 0;
  int tests_run = 0;

  initial begin
    forever #25 clock = ~clock;
  end

  phy_diag_regs phy_diag_regs_i (.clock(clock), .reset_n(reset_n),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(PHY), .link_1000_ok(link_1000_ok),
    .link_100_ok(link_100_ok), .rx_err_frame(rx_err_frame),
    .event_in(event_in), .diag_run(diag_run), .diag_pair(diag_pair),
    .diag_done(diag_done), .diag_status(diag_status),
    .diag_dist(diag_dist), .irq_pin(irq_pin));

  mgmt_master mgmt_master_i (.clock(clock), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  task automatic chk16(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // commit lands on the first clock edge after the last data rise
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    logic [15:0] x;
    mgmt_master_i.xfer(phy_diag_pkg::OP_WRITE, PHY, r, d, x);
    cyc(4);
  endtask

  task automatic rdc(input string nm, input logic [4:0] r,
                     input logic [15:0] e);
    logic [15:0] x;
    mgmt_master_i.xfer(phy_diag_pkg::OP_READ, PHY, r, 16'h0000, x);
    chk16(nm, e, x);
  endtask

  task automatic pulse_ev(input logic [7:0] m);
    event_in = m;
    cyc(1);
    event_in = 8'h00;
    cyc(4);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (98000) @(posedge clock);
    n_mismatch++;
    $display("mismatch watchdog expected end seen hang");
    complete_run();
  end

  initial begin
    cyc(2);
    reset_n = 1'b1;
    cyc(1);
    chk1("irq_pin", 1'b1, irq_pin);
    rdc("cable", 5'h12, 16'h0000);
    rdc("link", 5'h13, 16'h0000);
    rdc("rxerr", 5'h15, 16'h0000);
    rdc("intr", 5'h1b, 16'h0000);
    rdc("unmapped", 5'h10, 16'h0000);
    mgmt_master_i.xfer(2'h2, 5'h04, 5'h12, 16'h0000, rdv);
    chk16("other_phy", 16'hffff, rdv);
    mgmt_master_i.xfer(2'h3, PHY, 5'h1b, 16'h0000, rdv);
    chk16("bad_op", 16'hffff, rdv);
    mgmt_master_i.xfer(phy_diag_pkg::OP_WRITE, 5'h04, 5'h1b, 16'hfc00, rdv);
    rdc("other_phy_wr", 5'h1b, 16'h0000);
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      pr = p[1:0];
      wr(5'h12, {2'b00, pr, 12'h000});
      chk16("diag_pair", {14'h0, pr}, {14'h0, diag_pair});
      rdc("pair", 5'h12, {2'b00, pr, 12'h000});
      wr(5'h12, {2'b10, pr, 12'h000});
      chk1("diag_run", 1'b1, diag_run);
      rdc("running", 5'h12, {2'b10, pr, 12'h000});
      diag_status = pr;
      diag_dist = (pr == 2'h0) ? 8'h00 : 8'h40 + 8'(p);
      es = (pr == 2'h3) ? 2'h0 : pr;
      ed = (es == 2'h0) ? 8'h00 : diag_dist;
      diag_done = 1'b1;
      cyc(1);
      diag_done = 1'b0;
      cyc(2);
      chk1("diag_run_clr", 1'b0, diag_run);
      rdc("result", 5'h12, {2'b00, pr, 2'b00, es, ed});
      wr(5'h12, {2'b00, pr + 2'h1, 12'h000});
      rdc("new_pair", 5'h12, {2'b00, pr + 2'h1, 12'h000});
    end
    $display("test cable done");
    for (int k = 0; k < 4; k++) begin
      link_1000_ok = k[1];
      link_100_ok = k[0];
      cyc(2);
      rdc("link", 5'h13, {13'h0, k[1], k[0], 1'b0});
    end
    $display("test link done");
    rx_err_frame = 1'b1;
    cyc(3);
    rx_err_frame = 1'b0;
    cyc(2);
    rdc("rxerr_cnt", 5'h15, 16'h0003);
    rdc("rxerr_clr", 5'h15, 16'h0000);
    wr(5'h15, 16'h1234);
    rdc("rxerr_ro", 5'h15, 16'h0000);
    rx_err_frame = 1'b1;
    cyc(65540);
    rx_err_frame = 1'b0;
    rdc("rxerr_sat", 5'h15, 16'hffff);
    $display("test counter done");
    wr(5'h1b, 16'hfc00);
    rdc("enables", 5'h1b, 16'hfc00);
    for (int k = 0; k < 8; k++) begin
      pol = k[0];
      msk = 8'h01 << k;
      wr(5'h1f, {1'b0, pol, 14'h0000});
      rdc("polarity", 5'h1f, {1'b0, pol, 14'h0000});
      wr(5'h1b, 16'h0000);
      pulse_ev(msk);
      chk1("irq_masked", ~pol, irq_pin);
      rdc("flag", 5'h1b, {8'h00, msk});
      wr(5'h1b, {msk, 8'h00});
      pulse_ev(msk);
      chk1("irq_on", pol, irq_pin);
      rdc("en_flag", 5'h1b, {msk, msk});
      cyc(3);
      chk1("irq_off", ~pol, irq_pin);
    end
    $display("test interrupt done");
    complete_run();
  end
endmodule
